// ### i2c_div_pkg.sv
package i2c_div_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [2:0] ADDR_FREQ    = 3'h0;
    localparam logic [2:0] ADDR_CTRL    = 3'h1;
    localparam logic [2:0] ADDR_STATUS  = 3'h2;
    localparam logic [2:0] ADDR_MASK    = 3'h3;
    localparam logic [2:0] ADDR_CMD     = 3'h4;

    localparam logic [7:0] FREQ_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] MASK_RESET   = 8'h00;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int BIT_ENABLE  = 7;
    localparam int BIT_IRQ_EN  = 6;
    localparam int BIT_MASTER  = 5;
    localparam int BIT_TX      = 4;
    localparam int BIT_ACK_SUP = 3;
    localparam int BIT_RSTART  = 2;

    // Rate register: scale in [7:6], index in [5:0]
    localparam int SCALE_HI = 7;
    localparam int SCALE_LO = 6;

    // Status / mask bits
    localparam int EV_START = 0;
    localparam int EV_STOP  = 1;
    localparam int EV_RSTRT = 2;
    localparam int EV_ARBL  = 3;
    localparam int EV_TICK  = 4;

    // Command register bits
    localparam int CMD_ACK_CYCLE = 0;

    localparam int CNT_W = 14;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_SLAVE  = 3'b001,
        ST_START  = 3'b010,
        ST_MASTER = 3'b011,
        ST_RSTART = 3'b100,
        ST_STOP   = 3'b101
    } mode_t;

endpackage : i2c_div_pkg

// ### i2c_divider_and_control.sv
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module i2c_divider_and_control
    import i2c_div_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe_n,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic            master_mode,
    output logic            transmit_dir,
    output logic            arb_lost,
    output logic            irq
);
    // ****************************************
    // Registers and bus slave
    // ****************************************
    logic [7:0] freq_reg;
    logic [7:0] ctrl_reg;
    logic [4:0] status_reg;
    logic [4:0] status_next;
    logic [4:0] mask_reg;
    logic       ack_cycle_reg;
    logic [7:0] rdata_next;
    logic [4:0] events;
    logic       repeat_start_request_write;
    logic       master_prev_reg;
    logic       scl_s1_reg;
    logic       scl_s2_reg;
    logic       sda_s1_reg;
    logic       sda_s2_reg;
    mode_t      mode_reg;
    mode_t      mode_next;

    wire wr_freq = wr && addr == ADDR_FREQ;
    wire wr_ctrl = wr && addr == ADDR_CTRL;
    wire wr_mask = wr && addr == ADDR_MASK;
    wire wr_cmd  = wr && addr == ADDR_CMD;
    wire rd_stat = rd && addr == ADDR_STATUS;
    wire enabled = ctrl_reg[BIT_ENABLE];

    assign repeat_start_request_write = wr_ctrl && wdata[BIT_RSTART];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            freq_reg      <= FREQ_RESET;
            ctrl_reg      <= CTRL_RESET;
            mask_reg      <= MASK_RESET[4:0];
            ack_cycle_reg <= 1'b0;
        end else begin
            if (wr_freq) freq_reg <= wdata;
            if (wr_ctrl) ctrl_reg <= wdata & ~(8'h01 << BIT_RSTART);
            if (wr_mask) mask_reg <= wdata[4:0];
            if (wr_cmd) ack_cycle_reg <= wdata[CMD_ACK_CYCLE];
        end
    end

    assign rdata_next = (addr == ADDR_FREQ)   ? freq_reg :
                        (addr == ADDR_CTRL)   ? ctrl_reg :
                        (addr == ADDR_STATUS) ? {3'h0, status_reg} :
                        (addr == ADDR_MASK)   ? {3'h0, mask_reg} :
                        (addr == ADDR_CMD)    ? {7'h00, ack_cycle_reg} : 8'h00;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? rdata_next : 8'h00;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
        end else begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
        end
    end

    // ****************************************
    // Rate lookup and timer
    // ****************************************
    logic [11:0]      scl_div;
    logic [9:0]       sda_hold;
    logic [10:0]      start_hold;
    logic [10:0]      stop_hold;
    logic [2:0]       scale;
    logic             tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic             tmr_done;

    i2c_rate_table u_table (
        .mclk       (mclk),
        .rst        (rst),
        .rate_index (freq_reg[5:0]),
        .scl_div    (scl_div),
        .sda_hold   (sda_hold),
        .start_hold (start_hold),
        .stop_hold  (stop_hold)
    );

    // scale decode, reserved acts as 1
    assign scale = (freq_reg[SCALE_HI:SCALE_LO] == 2'h1) ? 3'h2 :
                   (freq_reg[SCALE_HI:SCALE_LO] == 2'h2) ? 3'h4 : 3'h1;

    // half period per phase, hold counts
    // Keyed on the next mode: the load happens on the edge that enters it
    always_comb begin
        case (mode_next)
            ST_START:  tmr_count = CNT_W'(start_hold);
            ST_RSTART: tmr_count = CNT_W'(start_hold);
            ST_STOP:   tmr_count = CNT_W'(stop_hold);
            ST_MASTER: tmr_count = CNT_W'(scl_div[11:1]);
            default:   tmr_count = CNT_W'(sda_hold);
        endcase
    end

    i2c_hold_timer u_timer (
        .mclk  (mclk),
        .rst   (rst),
        .load  (tmr_load),
        .count (tmr_count),
        .scale (scale),
        .done  (tmr_done)
    );

    // ****************************************
    // Mode sequencer
    // ****************************************
    logic scl_drv_reg;
    logic sda_drv_reg;
    logic bad_repeat_start_request;

    assign bad_repeat_start_request = repeat_start_request_write && enabled && mode_reg != ST_MASTER;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            ST_OFF:    if (enabled) mode_next = ST_SLAVE;
            ST_SLAVE:  if (ctrl_reg[BIT_MASTER] && !master_prev_reg) mode_next = ST_START;
            ST_START:  if (tmr_done) mode_next = ST_MASTER;
            ST_MASTER: begin
                if (!ctrl_reg[BIT_MASTER]) mode_next = ST_STOP;
                else if (repeat_start_request_write) mode_next = ST_RSTART;
            end
            ST_RSTART: if (tmr_done) mode_next = ST_MASTER;
            ST_STOP:   if (tmr_done) mode_next = ST_SLAVE;
            default:   mode_next = ST_OFF;
        endcase
        if (!enabled) mode_next = ST_OFF;
    end

    assign tmr_load = (mode_next != mode_reg) ||
                      (mode_reg == ST_MASTER && tmr_done);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_reg        <= ST_OFF;
            master_prev_reg <= 1'b0;
            scl_drv_reg     <= 1'b0;
            sda_drv_reg     <= 1'b0;
        end else begin
            mode_reg        <= mode_next;
            master_prev_reg <= ctrl_reg[BIT_MASTER] && enabled;
            if (mode_next == ST_MASTER && mode_reg == ST_MASTER && tmr_done)
                scl_drv_reg <= ~scl_drv_reg;
            else if (mode_next == ST_MASTER && mode_reg != ST_MASTER)
                scl_drv_reg <= 1'b1;
            else if (mode_next == ST_START || mode_next == ST_RSTART)
                scl_drv_reg <= 1'b0;
            else if (mode_next == ST_STOP || mode_next == ST_OFF || mode_next == ST_SLAVE)
                scl_drv_reg <= 1'b0;
            // SDA held low through the stop hold so its release is the stop
            sda_drv_reg <= (mode_next == ST_START || mode_next == ST_RSTART ||
                            mode_next == ST_STOP);
        end
    end

    wire ack_drive = enabled && ack_cycle_reg && !ctrl_reg[BIT_TX] &&
                     !ctrl_reg[BIT_ACK_SUP];

    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n = ~scl_drv_reg;
    assign sda_oe_n = ~(sda_drv_reg || ack_drive);

    assign master_mode = mode_reg == ST_MASTER || mode_reg == ST_START ||
                         mode_reg == ST_RSTART;
    assign transmit_dir = ctrl_reg[BIT_TX];

    // ****************************************
    // Events and interrupt
    // ****************************************
    assign events[EV_START] = mode_reg == ST_START && tmr_done;
    assign events[EV_STOP]  = mode_reg == ST_STOP && tmr_done;
    assign events[EV_RSTRT] = mode_reg == ST_RSTART && tmr_done;
    assign events[EV_ARBL]  = bad_repeat_start_request;
    assign events[EV_TICK]  = !scl_s2_reg && !sda_s2_reg && enabled && 1'b0;

    // Set wins over the read clear
    assign status_next = (rd_stat ? 5'h00 : status_reg) | events;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_reg <= 5'h00;
        end else begin
            status_reg <= status_next;
        end
    end

    assign arb_lost = status_reg[EV_ARBL];
    assign irq = ctrl_reg[BIT_IRQ_EN] && |(status_reg & mask_reg);

    // ****************************************
    // Checks
    // ****************************************
    chk_irq_gate: assert property (@(posedge mclk) disable iff (rst)
        !ctrl_reg[BIT_IRQ_EN] |-> !irq) else $error("irq without enable");
    chk_off_mode: assert property (@(posedge mclk) disable iff (rst)
        !enabled |=> mode_reg == ST_OFF) else $error("active while disabled");
    chk_start_seq: assert property (@(posedge mclk) disable iff (rst)
        mode_reg == ST_SLAVE && enabled && ctrl_reg[BIT_MASTER] && !master_prev_reg
        |=> mode_reg == ST_START) else $error("no start");
    chk_stop_seq: assert property (@(posedge mclk) disable iff (rst)
        mode_reg == ST_MASTER && enabled && !ctrl_reg[BIT_MASTER]
        |=> mode_reg == ST_STOP) else $error("no stop");
    chk_repeat_start_request_read: assert property (@(posedge mclk) disable iff (rst)
        $past(rd) && $past(addr) == ADDR_CTRL |-> !rdata[BIT_RSTART])
        else $error("repeat start read as 1");
    chk_repeat_start_request_arbl: assert property (@(posedge mclk) disable iff (rst)
        bad_repeat_start_request |=> status_reg[EV_ARBL]) else $error("arbitration not flagged");
    chk_ack_drive: assert property (@(posedge mclk) disable iff (rst)
        ctrl_reg[BIT_ACK_SUP] && !sda_drv_reg |-> sda_oe_n) else $error("ack driven");
    chk_dir_follow: assert property (@(posedge mclk) disable iff (rst)
        $past(wr_ctrl) |-> transmit_dir == $past(wdata[BIT_TX])) else $error("direction");
    chk_repeat_start_request_master: assert property (@(posedge mclk) disable iff (rst)
        mode_reg == ST_MASTER && enabled && ctrl_reg[BIT_MASTER] && repeat_start_request_write
        |=> mode_reg == ST_RSTART) else $error("no repeated start");

    cov_start: cover property (@(posedge mclk) disable iff (rst) events[EV_START]);
    cov_stop:  cover property (@(posedge mclk) disable iff (rst) events[EV_STOP]);
    cov_repeat_start_request:  cover property (@(posedge mclk) disable iff (rst) events[EV_RSTRT]);
    cov_irq:   cover property (@(posedge mclk) disable iff (rst) irq);
endmodule : i2c_divider_and_control
`default_nettype wire

// ### i2c_hold_timer.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_hold_timer
    import i2c_div_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] count,
    input  wire logic [2:0]       scale,
    output logic                  done
);
    // ****************************************
    // Prescaled down counter
    // ****************************************
    logic [CNT_W-1:0] cnt_reg;
    logic [2:0]       pre_reg;
    logic             busy_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= '0;
            pre_reg  <= 3'h0;
            busy_reg <= 1'b0;
        end else if (load) begin
            cnt_reg  <= count;
            pre_reg  <= 3'(scale - 3'h1);
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            if (pre_reg != 3'h0) begin
                pre_reg <= 3'(pre_reg - 3'h1);
            end else if (cnt_reg <= CNT_W'(1)) begin
                busy_reg <= 1'b0;
            end else begin
                cnt_reg <= CNT_W'(cnt_reg - 1'b1);
                pre_reg <= 3'(scale - 3'h1);
            end
        end
    end

    assign done = busy_reg && pre_reg == 3'h0 && cnt_reg <= CNT_W'(1);
endmodule : i2c_hold_timer
`default_nettype wire

// ### i2c_line_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Far side of the two-wire bus
// ****************************************
// Pull-ups only: a released line reads high, never the last driven value
module i2c_line_partner (
    input  wire logic scl_out,
    input  wire logic scl_oe_n,
    input  wire logic sda_out,
    input  wire logic sda_oe_n,
    output logic      scl_bus,
    output logic      sda_bus
);
    assign scl_bus = scl_oe_n ? 1'b1 : scl_out;
    assign sda_bus = sda_oe_n ? 1'b1 : sda_out;
endmodule : i2c_line_partner
`default_nettype wire

// ### i2c_rate_table.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_rate_table
    import i2c_div_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [5:0]       rate_index,
    output logic      [11:0]      scl_div,
    output logic      [9:0]       sda_hold,
    output logic      [10:0]      start_hold,
    output logic      [10:0]      stop_hold
);
    // ****************************************
    // Upper divider table, registered output
    // ****************************************
    // Index bit 5 is not decoded: the lower half of the index range gives the same entries as the upper half
    logic [11:0] div_w;
    logic [9:0]  sda_w;
    logic [10:0] sta_w;
    logic [11:0] base;

    function automatic logic [11:0] base_of(input logic [1:0] g);
        case (g)
            2'h0: base_of = 12'h020;
            2'h1: base_of = 12'h040;
            2'h2: base_of = 12'h080;
            default: base_of = 12'h100;
        endcase
    endfunction : base_of

    always_comb begin
        base = base_of(rate_index[4:3]);
        case ({rate_index[2], rate_index[1:0]})
            3'h0: div_w = 12'(base * 5);
            3'h1: div_w = 12'(base * 6);
            3'h2: div_w = 12'(base * 7);
            3'h3: div_w = 12'(base * 8);
            3'h4: div_w = 12'(base * 9);
            3'h5: div_w = 12'(base * 10);
            3'h6: div_w = 12'(base * 12);
            default: div_w = 12'(base * 15);
        endcase
        // Hold step is half the base, one to four steps chosen by bits 2:1
        sda_w = 10'((base >> 1) * ({1'b0, rate_index[2:1]} + 3'h1) + 1);
        sta_w = 11'(div_w / 2 - 2);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_div    <= 12'h0a0;
            sda_hold   <= 10'h011;
            start_hold <= 11'h04e;
            stop_hold  <= 11'h051;
        end else begin
            scl_div    <= div_w;
            sda_hold   <= sda_w;
            start_hold <= sta_w;
            stop_hold  <= 11'(sta_w + 3);
        end
    end

endmodule : i2c_rate_table
`default_nettype wire

// ### tb_i2c_divider_and_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_divider_and_control;
    import i2c_div_pkg::*;
    logic       mclk, rst, wr, rd;
    logic [2:0] addr;
    logic [7:0] wdata, rv;
    wire  logic [7:0] rdata;
    wire  logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_bus, sda_bus;
    wire  logic master_mode, transmit_dir, arb_lost, irq;
    int         miscompares, total_checks, cycles, n;

    i2c_divider_and_control DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_bus), .sda_in(sda_bus),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .master_mode(master_mode), .transmit_dir(transmit_dir), .arb_lost(arb_lost),
        .irq(irq));
    i2c_line_partner far_side (.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .scl_bus(scl_bus), .sda_bus(sda_bus));

    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    // Bounded wait on the interrupt line, counting cycles
    task automatic wait_irq(input int limit, output int c);
        c = 0;
        while (irq !== 1'b1 && c < limit) begin
            @(posedge mclk);
            #1 c++;
        end
    endtask : wait_irq

    task automatic idle(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : idle

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_regs();
        reg_rd(ADDR_CTRL, rv);
        check("ctrl reset", CTRL_RESET, rv);
        reg_rd(ADDR_FREQ, rv);
        check("rate reset", FREQ_RESET, rv);
        reg_rd(ADDR_MASK, rv);
        check("mask reset", MASK_RESET, rv);
        reg_wr(3'h7, 8'hff);
        reg_rd(3'h7, rv);
        check("unmapped", 8'h00, rv);
        reg_wr(ADDR_FREQ, 8'h5a);
        reg_rd(ADDR_FREQ, rv);
        check("rate rw", 8'h5a, rv);
        reg_wr(ADDR_CTRL, 8'h3c);
        reg_rd(ADDR_CTRL, rv);
        check("repeat start reads 0", 8'h38, rv);
        idle(30);
        check("tx dir", 1'b1, transmit_dir);
        check("off no master", 1'b0, master_mode);
        check("off sda idle", 1'b1, sda_oe_n);
        check("open drain pins low", 2'h0, {scl_out, sda_out});
        reg_wr(ADDR_CTRL, 8'h00);
        $display("test_regs done");
    endtask : test_regs

    // Start then stop at one rate setting, timing both holds
    task automatic test_frame(input logic [7:0] rate, input int st, input int sp,
                              input int hp);
        logic lvl;
        reg_wr(ADDR_FREQ, rate);
        reg_wr(ADDR_MASK, 8'h01);
        reg_wr(ADDR_CTRL, 8'hd0);
        idle(4);
        // tx held high for the address cycle
        reg_wr(ADDR_CTRL, 8'hf0);
        n = 0;
        while (sda_oe_n !== 1'b0 && n < 10) begin
            @(posedge mclk);
            #1 n++;
        end
        check("start sda low", 1'b0, sda_oe_n);
        check("master mode", 1'b1, master_mode);
        wait_irq(st + 20, n);
        check("start hold near", 1'b1, (n >= st - 4) && (n <= st + 4));
        reg_rd(ADDR_STATUS, rv);
        check("start event", 1'b1, rv[EV_START]);
        idle(2);
        check("irq cleared", 1'b0, irq);
        // Half of the serial clock period, edge to edge of the drive enable
        lvl = scl_oe_n;
        n = 0;
        while (scl_oe_n === lvl && n < hp + 10) begin
            @(posedge mclk);
            #1 n++;
        end
        lvl = scl_oe_n;
        n = 0;
        while (scl_oe_n === lvl && n < hp + 10) begin
            @(posedge mclk);
            #1 n++;
        end
        check("scl half period", hp, n);
        reg_wr(ADDR_MASK, 8'h02);
        reg_wr(ADDR_CTRL, 8'hd0);
        wait_irq(sp + 30, n);
        check("stop hold near", 1'b1, (n >= sp - 6) && (n <= sp + 6));
        check("slave again", 1'b0, master_mode);
        check("sda released", 1'b1, sda_oe_n);
        reg_rd(ADDR_STATUS, rv);
        check("stop event", 1'b1, rv[EV_STOP]);
        $display("test_frame rate %h done", rate);
    endtask : test_frame

    task automatic test_irq_gate();
        reg_wr(ADDR_FREQ, 8'h20);
        reg_wr(ADDR_MASK, 8'h1f);
        reg_wr(ADDR_CTRL, 8'h90);
        idle(4);
        reg_wr(ADDR_CTRL, 8'hb0);
        idle(120);
        check("no irq when disabled", 1'b0, irq);
        reg_rd(ADDR_STATUS, rv);
        check("event still kept", 1'b1, rv[EV_START]);
        reg_wr(ADDR_CTRL, 8'h90);
        idle(120);
        reg_rd(ADDR_STATUS, rv);
        $display("test_irq_gate done");
    endtask : test_irq_gate

    task automatic test_rstart();
        reg_wr(ADDR_MASK, 8'h04);
        reg_wr(ADDR_CTRL, 8'hf0);
        idle(120);
        reg_rd(ADDR_STATUS, rv);
        reg_wr(ADDR_CTRL, 8'hf4);
        wait_irq(400, n);
        check("repeat start irq", 1'b1, irq);
        reg_rd(ADDR_STATUS, rv);
        check("repeat start event", 1'b1, rv[EV_RSTRT]);
        check("no arb loss", 1'b0, arb_lost);
        reg_wr(ADDR_CTRL, 8'hd0);
        idle(200);
        reg_rd(ADDR_STATUS, rv);
        reg_wr(ADDR_MASK, 8'h08);
        reg_wr(ADDR_CTRL, 8'hd4);
        wait_irq(20, n);
        check("wrong time arb lost", 1'b1, arb_lost);
        reg_rd(ADDR_STATUS, rv);
        check("arb event", 1'b1, rv[EV_ARBL]);
        idle(2);
        check("arb cleared", 1'b0, arb_lost);
        $display("test_rstart done");
    endtask : test_rstart

    task automatic test_ack();
        // receive chosen as a slave written to by the far master
        reg_wr(ADDR_CTRL, 8'h80);
        reg_wr(ADDR_CMD, 8'h01);
        idle(2);
        check("rx dir", 1'b0, transmit_dir);
        check("ack driven", 1'b0, sda_oe_n);
        reg_wr(ADDR_CMD, 8'h00);
        reg_wr(ADDR_CTRL, 8'h88);
        reg_wr(ADDR_CMD, 8'h01);
        idle(2);
        check("no ack", 1'b1, sda_oe_n);
        reg_wr(ADDR_CMD, 8'h00);
        reg_wr(ADDR_CTRL, 8'h00);
        $display("test_ack done");
    endtask : test_ack

    // ****************************************
    // Run control
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // Whole run is near 14000 cycles; the ceiling leaves ample margin
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        test_regs();
        test_frame(8'h20, 78, 81, 80);
        test_frame(8'h60, 156, 162, 160);
        test_frame(8'hab, 1016, 1028, 1024);
        test_frame(8'he0, 78, 81, 80);
        test_frame(8'h3f, 1918, 1921, 1920);
        test_irq_gate();
        test_rstart();
        test_ack();
        print_verdict();
    end
endmodule : tb_i2c_divider_and_control
`default_nettype wire
